// >>> verilog/lsh_cfg.svh
// Constants for the LIN slave header sync block and its bus master partner
`ifndef LSH_CFG_SVH
`define LSH_CFG_SVH
// Behaviour
// - Master holds break low thirteen bits minimum
// - Slave detects break at any time
// - Bus stuck low raises an error flag
// - Time first to fifth sync edge, divide eight
// - PID holds six-bit id plus parity
// - Frame carries one to eight data bytes
// - Software derives divisors from measured sync count
// - Transmit, receive and line status registers work
// - UART lines can route to GPIO pins
// - Break compare fires when timer exceeds compare
// - Sync timer counts edges, stop interrupt
// - Software ungates receive only with bus high
// - Port 2 data bit 4 reads bus
// - Port 2 control bit 20 hands pin drive to port 2 data bit 5
// - Short sets flag, re-enable clears, can disable
// - Break timer twelve bits, cleared by edge/read
// - Overflow flags break error, compare resets 0x47

//****************************************************************
// Timing
//****************************************************************
`define LSH_CLK_HZ     100000000
`define LSH_LPO_HZ     131000
`define LSH_LPO_DIV    (`LSH_CLK_HZ / `LSH_LPO_HZ)
`define LSH_BAUD       20000
`define LSH_BIT_CYC    (`LSH_CLK_HZ / `LSH_BAUD)
`define LSH_BRK_BITS   4'hD
`define LSH_SHORT_CYC  4'h8
`define LSH_SYNC_BYTE  8'h55

//****************************************************************
// Reset values
//****************************************************************
`define LSH_CMP_RST    12'h047
`define LSH_BT_MAX     12'hFFF
`define LSH_STOP_RST   4'h5
`define LSH_DIV_RST    16'h1388

//****************************************************************
// Register offsets
//****************************************************************
`define LSH_A_BTV      8'h00
`define LSH_A_ETMR     8'h04
`define LSH_A_CTRL     8'h08
`define LSH_A_SEL      8'h0C
`define LSH_A_FLAGS    8'h10
`define LSH_A_CLR      8'h14
`define LSH_A_IEN      8'h18
`define LSH_A_TX       8'h1C
`define LSH_A_RX       8'h20
`define LSH_A_LS       8'h24
`define LSH_A_LCR      8'h28
`define LSH_A_DIVL     8'h2C
`define LSH_A_DIVH     8'h30
`define LSH_A_FRAC     8'h34
`define LSH_A_P1CON    8'h38
`define LSH_A_P2CON    8'h3C
`define LSH_A_P2DAT    8'h40
`define LSH_A_HV_STATE    8'h44
`define LSH_A_HVCFG    8'h48

//****************************************************************
// Field positions
//****************************************************************
`define LSH_C_RST      0
`define LSH_C_EN       2
`define LSH_C_GATE     8
`define LSH_P1_MUX     0
`define LSH_P2_GPIO    20
`define LSH_P2_RB      4
`define LSH_P2_DRV     5
`define LSH_HV_SHORT   2
`define LSH_HC_DIS     2
`define LSH_HC_REEN    3
`define LSH_I_BRK      0
`define LSH_I_STOP     1
`define LSH_I_BERR     2
`define LSH_I_RX       3
`define LSH_I_SHORT    4
`define LSH_LS_DR      0
`define LSH_LS_OVR     1
`define LSH_LS_FE      3
`define LSH_LS_TEMT    5
`define LSH_FL_ST      8
`endif

// >>> verilog/lsh_pkg.sv
// Types for the LIN slave header sync block and its bus master partner
package lsh_pkg;
	typedef enum logic [4:0] {
		LSH_S_IDLE  = 5'h01,
		LSH_S_BRK   = 5'h02,
		LSH_S_WSYNC = 5'h04,
		LSH_S_SYNC  = 5'h08,
		LSH_S_DONE  = 5'h10
	} lsh_sst_t;

	typedef enum logic [3:0] {
		LSH_M_IDLE = 4'h1,
		LSH_M_BRK  = 4'h2,
		LSH_M_DEL  = 4'h4,
		LSH_M_BYTE = 4'h8
	} lsh_mst_t;

	typedef struct packed {
		logic [2:0]  ls;
		logic        lvl;
		logic [2:0]  gs;
		logic        glvl;
		logic [15:0] lpo;
		logic [11:0] bt;
		logic [11:0] cmp;
		logic        brk_hit;
		logic        berr_hit;
		lsh_sst_t    st;
		logic [15:0] etmr;
		logic [3:0]  ecnt;
		logic [3:0]  stop_sel;
		logic        en;
		logic        gate;
		logic [4:0]  flags;
		logic [4:0]  ien;
		logic [7:0]  txh;
		logic        tx_full;
		logic [9:0]  tx_sh;
		logic [3:0]  tx_bits;
		logic [15:0] tx_cnt;
		logic        txd;
		logic [3:0]  rx_bits;
		logic [7:0]  rx_sh;
		logic [15:0] rx_cnt;
		logic [7:0]  rxh;
		logic        dr;
		logic        ovr;
		logic        fe;
		logic [7:0]  lcr;
		logic [15:0] div;
		logic [15:0] frac;
		logic        p1mux;
		logic        p2gpio;
		logic        p2drv;
		logic        short;
		logic        prot_dis;
		logic [3:0]  sh_cnt;
		logic        lin_oe;
		logic        gpio_txd;
		logic        irq;
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} lsh_slv_t;

	typedef struct packed {
		lsh_mst_t    st;
		logic [15:0] cnt;
		logic [3:0]  bits;
		logic [3:0]  idx;
		logic [3:0]  nb;
		logic [7:0]  pid;
		logic [63:0] dat;
		logic [9:0]  sh;
		logic        oe;
		logic        busy;
		logic        done;
	} lsh_mst_s_t;
endpackage : lsh_pkg

// >>> verilog/lsh_if.sv
// Open-drain LIN wire joining the master end and the slave end
`timescale 1ns/100ps
interface lsh_if;
	logic m_oe;
	logic s_oe;
	logic level;

	// Wired-AND: any enabled driver pulls the bus low, else pulled up
	assign level = ~(m_oe | s_oe);

	modport master (output m_oe);
	modport slave  (output s_oe, input level);
endinterface : lsh_if

// >>> verilog/lsh_slave.sv
// LIN slave: break and sync detection, embedded UART, pin diagnostics, APB slave
`timescale 1ns/100ps
`include "lsh_cfg.svh"
module lsh_slave
	import lsh_pkg::*;
#(
	parameter logic [15:0] LPO_DIV = 16'(`LSH_LPO_DIV)
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        ce,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             irq,
	input  wire logic        gpio_rxd,
	output logic             gpio_txd,
	lsh_if.slave             bus
);
	lsh_slv_t s_r;
	lsh_slv_t s_nxt;

	//****************************************************************
	// Next state
	//****************************************************************
	always_comb begin
		logic        fall;
		logic        rise;
		logic        tick;
		logic        setup;
		logic        wr;
		logic        rd;
		logic        rx_in;
		logic        drive_lo;
		logic        hit;
		logic [4:0]  ev;
		logic [4:0]  clr;
		logic [31:0] rdat;
		fall = 1'b0;
		rise = 1'b0;
		tick = 1'b0;
		setup = psel & ~penable;
		wr = psel & penable & s_r.pready & pwrite;
		rd = psel & penable & s_r.pready & ~pwrite;
		rx_in = 1'b1;
		drive_lo = 1'b0;
		hit = 1'b1;
		ev = '0;
		clr = '0;
		rdat = '0;
		s_nxt = s_r;

		// Three-stage pin sync; a level counts once stages two and three agree
		s_nxt.ls = {s_r.ls[1:0], bus.level};
		s_nxt.gs = {s_r.gs[1:0], gpio_rxd};
		if (s_r.ls[1] == s_r.ls[2]) begin
			s_nxt.lvl = s_r.ls[2];
		end
		if (s_r.gs[1] == s_r.gs[2]) begin
			s_nxt.glvl = s_r.gs[2];
		end
		fall = s_r.lvl & ~s_nxt.lvl;
		rise = ~s_r.lvl & s_nxt.lvl;

		// Register read mux, sampled in the setup cycle so prdata is a flop
		unique case (paddr)
			`LSH_A_BTV:   rdat = {20'h0, s_r.bt};
			`LSH_A_ETMR:  rdat = {3'h0, s_r.etmr[15:3], s_r.etmr};
			`LSH_A_CTRL: begin
				rdat[`LSH_C_EN] = s_r.en;
				rdat[`LSH_C_GATE] = s_r.gate;
			end
			`LSH_A_SEL:   rdat = {28'h0, s_r.stop_sel};
			`LSH_A_FLAGS: rdat = {19'h0, s_r.st, 3'h0, s_r.flags};
			`LSH_A_IEN:   rdat = {27'h0, s_r.ien};
			`LSH_A_CLR, `LSH_A_TX: rdat = '0;
			`LSH_A_RX:    rdat = {24'h0, s_r.rxh};
			`LSH_A_LS: begin
				rdat[`LSH_LS_DR] = s_r.dr;
				rdat[`LSH_LS_OVR] = s_r.ovr;
				rdat[`LSH_LS_FE] = s_r.fe;
				rdat[`LSH_LS_TEMT] = ~s_r.tx_full & (s_r.tx_bits == 4'h0);
			end
			`LSH_A_LCR:   rdat = {24'h0, s_r.lcr};
			`LSH_A_DIVL:  rdat = {24'h0, s_r.div[7:0]};
			`LSH_A_DIVH:  rdat = {24'h0, s_r.div[15:8]};
			`LSH_A_FRAC:  rdat = {16'h0, s_r.frac};
			`LSH_A_P1CON: rdat[`LSH_P1_MUX] = s_r.p1mux;
			`LSH_A_P2CON: rdat[`LSH_P2_GPIO] = s_r.p2gpio;
			`LSH_A_P2DAT: begin
				rdat[`LSH_P2_RB] = s_r.lvl;
				rdat[`LSH_P2_DRV] = s_r.p2drv;
			end
			`LSH_A_HV_STATE: rdat[`LSH_HV_SHORT] = s_r.short;
			`LSH_A_HVCFG: rdat[`LSH_HC_DIS] = s_r.prot_dis;
			default:      hit = 1'b0;
		endcase
		s_nxt.pready = setup;
		s_nxt.pslverr = setup & ~hit;
		if (setup) begin
			s_nxt.prdata = rdat;
		end

		// Read side effects come first so a same-cycle hardware set wins
		if (rd && paddr == `LSH_A_RX) begin
			s_nxt.dr = 1'b0;
		end
		if (rd && paddr == `LSH_A_LS) begin
			s_nxt.ovr = 1'b0;
			s_nxt.fe = 1'b0;
		end

		// Register writes
		if (wr) begin
			unique case (paddr)
				`LSH_A_BTV:   s_nxt.cmp = pwdata[11:0];
				`LSH_A_CTRL: begin
					s_nxt.en = pwdata[`LSH_C_EN];
					s_nxt.gate = pwdata[`LSH_C_GATE];
					if (pwdata[`LSH_C_RST]) begin
						s_nxt.st = LSH_S_IDLE;
						s_nxt.etmr = '0;
						s_nxt.ecnt = '0;
						s_nxt.brk_hit = 1'b0;
						s_nxt.berr_hit = 1'b0;
					end
				end
				`LSH_A_SEL:   s_nxt.stop_sel = pwdata[3:0];
				`LSH_A_CLR:   clr = pwdata[4:0];
				`LSH_A_IEN:   s_nxt.ien = pwdata[4:0];
				`LSH_A_LCR:   s_nxt.lcr = pwdata[7:0];
				`LSH_A_DIVL:  s_nxt.div[7:0] = pwdata[7:0];
				`LSH_A_DIVH:  s_nxt.div[15:8] = pwdata[7:0];
				`LSH_A_FRAC:  s_nxt.frac = pwdata[15:0];
				`LSH_A_P1CON: s_nxt.p1mux = pwdata[`LSH_P1_MUX];
				`LSH_A_P2CON: s_nxt.p2gpio = pwdata[`LSH_P2_GPIO];
				`LSH_A_P2DAT: s_nxt.p2drv = pwdata[`LSH_P2_DRV];
				`LSH_A_HVCFG: begin
					s_nxt.prot_dis = pwdata[`LSH_HC_DIS];
					if (pwdata[`LSH_HC_REEN]) begin
						s_nxt.short = 1'b0;
					end
				end
				default: ;
			endcase
		end

		// Break timer on a divided tick standing in for the low-power clock
		tick = (s_r.lpo == LPO_DIV - 16'h0001);
		s_nxt.lpo = tick ? 16'h0000 : s_r.lpo + 16'h0001;
		if (tick && s_r.bt != `LSH_BT_MAX) begin
			s_nxt.bt = s_r.bt + 12'h001;
		end
		if (fall || (rd && paddr == `LSH_A_BTV)) begin
			s_nxt.bt = '0;
			s_nxt.lpo = '0;
		end

		// Sync measurement, only after a valid break
		unique case (s_r.st)
			LSH_S_IDLE: ;
			LSH_S_BRK: begin
				if (rise) begin
					s_nxt.st = LSH_S_WSYNC;
				end
			end
			LSH_S_WSYNC: begin
				if (fall) begin
					s_nxt.st = LSH_S_SYNC;
					s_nxt.etmr = '0;
					s_nxt.ecnt = 4'h1;
				end
			end
			LSH_S_SYNC: begin
				if (s_r.etmr != 16'hFFFF) begin
					s_nxt.etmr = s_r.etmr + 16'h0001;
				end
				if (fall) begin
					s_nxt.ecnt = s_r.ecnt + 4'h1;
					if (s_r.ecnt + 4'h1 == s_r.stop_sel) begin
						ev[`LSH_I_STOP] = 1'b1;
						s_nxt.st = LSH_S_DONE;
					end
				end
			end
			LSH_S_DONE: ;
		endcase

		// Break checks override any state, even mid-sync or mid-data
		if (fall) begin
			s_nxt.brk_hit = 1'b0;
			s_nxt.berr_hit = 1'b0;
		end else if (s_r.en && !s_r.lvl) begin
			if (!s_r.brk_hit && s_r.bt > s_r.cmp) begin
				ev[`LSH_I_BRK] = 1'b1;
				s_nxt.brk_hit = 1'b1;
				s_nxt.st = LSH_S_BRK;
			end
			if (!s_r.berr_hit && s_r.bt == `LSH_BT_MAX) begin
				ev[`LSH_I_BERR] = 1'b1;
				s_nxt.berr_hit = 1'b1;
				s_nxt.st = LSH_S_IDLE;
			end
		end
		if (!s_nxt.en) begin
			s_nxt.st = LSH_S_IDLE;
		end

		// UART transmitter; a write loads after the shifter takes the old byte
		if (s_r.tx_bits == 4'h0) begin
			if (s_r.tx_full) begin
				s_nxt.tx_sh = {1'b1, s_r.txh, 1'b0};
				s_nxt.tx_bits = 4'hA;
				s_nxt.tx_cnt = s_r.div - 16'h0001;
				s_nxt.tx_full = 1'b0;
			end
		end else if (s_r.tx_cnt == 16'h0000) begin
			s_nxt.tx_sh = {1'b1, s_r.tx_sh[9:1]};
			s_nxt.tx_bits = s_r.tx_bits - 4'h1;
			s_nxt.tx_cnt = s_r.div - 16'h0001;
		end else begin
			s_nxt.tx_cnt = s_r.tx_cnt - 16'h0001;
		end
		if (wr && paddr == `LSH_A_TX) begin
			s_nxt.txh = pwdata[7:0];
			s_nxt.tx_full = 1'b1;
		end
		s_nxt.txd = (s_nxt.tx_bits != 4'h0) ? s_nxt.tx_sh[0] : 1'b1;

		// UART receiver; gate holds the bus path idle during the header
		rx_in = s_r.p1mux ? s_r.glvl : (s_r.gate | s_r.lvl);
		if (s_r.rx_bits == 4'h0) begin
			if (!rx_in) begin
				s_nxt.rx_bits = 4'h1;
				s_nxt.rx_cnt = {1'b0, s_r.div[15:1]};
			end
		end else if (s_r.rx_cnt != 16'h0000) begin
			s_nxt.rx_cnt = s_r.rx_cnt - 16'h0001;
		end else begin
			s_nxt.rx_cnt = s_r.div - 16'h0001;
			s_nxt.rx_bits = s_r.rx_bits + 4'h1;
			if (s_r.rx_bits == 4'h1 && rx_in) begin
				s_nxt.rx_bits = 4'h0; // False start, glitch rejected
			end else if (s_r.rx_bits == 4'hA) begin
				s_nxt.rx_bits = 4'h0;
				s_nxt.rxh = s_r.rx_sh;
				s_nxt.fe = ~rx_in | s_nxt.fe;
				s_nxt.ovr = s_r.dr | s_nxt.ovr;
				s_nxt.dr = 1'b1;
				ev[`LSH_I_RX] = 1'b1;
			end else if (s_r.rx_bits != 4'h1) begin
				s_nxt.rx_sh = {rx_in, s_r.rx_sh[7:1]};
			end
		end

		// Pin drive and short protection: driving low yet reading high
		if (s_r.lin_oe && s_r.lvl && !s_r.prot_dis) begin
			s_nxt.sh_cnt = s_r.sh_cnt + 4'h1;
			if (s_r.sh_cnt == `LSH_SHORT_CYC) begin
				s_nxt.short = 1'b1;
				ev[`LSH_I_SHORT] = 1'b1;
				s_nxt.sh_cnt = '0;
			end
		end else begin
			s_nxt.sh_cnt = '0;
		end
		drive_lo = s_nxt.p2gpio ? ~s_nxt.p2drv : (~s_nxt.p1mux & ~s_nxt.txd);
		s_nxt.lin_oe = drive_lo & ~s_nxt.short;
		s_nxt.gpio_txd = s_nxt.p1mux ? s_nxt.txd : 1'b1;

		// Sticky events: a set in the clearing cycle survives
		s_nxt.flags = (s_r.flags & ~clr) | ev;
		s_nxt.irq = |(s_nxt.flags & s_nxt.ien);
	end

	//****************************************************************
	// State register
	//****************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= '{ls: 3'h7, lvl: 1'b1, gs: 3'h7, glvl: 1'b1, cmp: `LSH_CMP_RST,
				st: LSH_S_IDLE, stop_sel: `LSH_STOP_RST, txd: 1'b1,
				div: `LSH_DIV_RST, gpio_txd: 1'b1, default: '0};
		end else if (ce) begin
			s_r <= s_nxt;
		end
	end

	assign prdata = s_r.prdata;
	assign pready = s_r.pready;
	assign pslverr = s_r.pslverr;
	assign irq = s_r.irq;
	assign gpio_txd = s_r.gpio_txd;
	assign bus.s_oe = s_r.lin_oe;
endmodule : lsh_slave

// >>> verilog/lsh_master.sv
// LIN bus master end: sends break, sync byte, protected id and data bytes
`timescale 1ns/100ps
`include "lsh_cfg.svh"
module lsh_master
	import lsh_pkg::*;
#(
	parameter int unsigned BIT_CYC = `LSH_BIT_CYC
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        ce,
	input  wire logic        start,
	input  wire logic [5:0]  pid,
	input  wire logic [3:0]  ndata,
	input  wire logic [63:0] data,
	output logic             busy,
	output logic             done,
	lsh_if.master            bus
);
	lsh_mst_s_t m_r;
	lsh_mst_s_t m_nxt;

	// Identifier with its two parity bits on top
	function automatic logic [7:0] lsh_pid_par(input logic [5:0] id);
		lsh_pid_par = {~(id[1] ^ id[3] ^ id[4] ^ id[5]), id[0] ^ id[1] ^ id[2] ^ id[4], id};
	endfunction : lsh_pid_par

	// Byte n of the frame after the break, framed with start and stop
	function automatic logic [9:0] lsh_frame(input logic [3:0] idx, input logic [7:0] p,
		input logic [63:0] d);
		logic [63:0] t;
		t = d >> {idx - 4'h2, 3'h0};
		if (idx == 4'h0) begin
			lsh_frame = {1'b1, `LSH_SYNC_BYTE, 1'b0};
		end else if (idx == 4'h1) begin
			lsh_frame = {1'b1, p, 1'b0};
		end else begin
			lsh_frame = {1'b1, t[7:0], 1'b0};
		end
	endfunction : lsh_frame

	//****************************************************************
	// Next state
	//****************************************************************
	always_comb begin
		logic tk;
		tk = (m_r.cnt == 16'h0000);
		m_nxt = m_r;
		m_nxt.done = 1'b0;
		if (!tk) begin
			m_nxt.cnt = m_r.cnt - 16'h0001;
		end
		unique case (m_r.st)
			LSH_M_IDLE: begin
				if (start) begin
					m_nxt.st = LSH_M_BRK;
					m_nxt.pid = lsh_pid_par(pid);
					m_nxt.dat = data;
					m_nxt.nb = (ndata == 4'h0) ? 4'h3 :
						(ndata > 4'h8) ? 4'hA : ndata + 4'h2;
					m_nxt.bits = `LSH_BRK_BITS - 4'h1;
					m_nxt.cnt = 16'(BIT_CYC - 1);
					m_nxt.oe = 1'b1;
				end
			end
			LSH_M_BRK: begin
				if (tk) begin
					m_nxt.cnt = 16'(BIT_CYC - 1);
					m_nxt.bits = m_r.bits - 4'h1;
					if (m_r.bits == 4'h0) begin
						m_nxt.st = LSH_M_DEL;
						m_nxt.oe = 1'b0;
					end
				end
			end
			LSH_M_DEL: begin
				if (tk) begin
					m_nxt.st = LSH_M_BYTE;
					m_nxt.idx = 4'h0;
					m_nxt.sh = lsh_frame(4'h0, m_r.pid, m_r.dat);
					m_nxt.bits = 4'h9;
					m_nxt.cnt = 16'(BIT_CYC - 1);
				end
			end
			LSH_M_BYTE: begin
				if (tk) begin
					m_nxt.cnt = 16'(BIT_CYC - 1);
					if (m_r.bits != 4'h0) begin
						m_nxt.sh = {1'b1, m_r.sh[9:1]};
						m_nxt.bits = m_r.bits - 4'h1;
					end else if (m_r.idx + 4'h1 == m_r.nb) begin
						m_nxt.st = LSH_M_IDLE;
						m_nxt.done = 1'b1;
					end else begin
						m_nxt.idx = m_r.idx + 4'h1;
						m_nxt.sh = lsh_frame(m_r.idx + 4'h1, m_r.pid, m_r.dat);
						m_nxt.bits = 4'h9;
					end
				end
			end
		endcase
		if (m_nxt.st == LSH_M_BYTE) begin
			m_nxt.oe = ~m_nxt.sh[0];
		end else if (m_nxt.st != LSH_M_BRK) begin
			m_nxt.oe = 1'b0;
		end
		m_nxt.busy = (m_nxt.st != LSH_M_IDLE);
	end

	//****************************************************************
	// State register
	//****************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			m_r <= '{st: LSH_M_IDLE, default: '0};
		end else if (ce) begin
			m_r <= m_nxt;
		end
	end

	assign busy = m_r.busy;
	assign done = m_r.done;
	assign bus.m_oe = m_r.oe;
endmodule : lsh_master

// >>> test/lsh_monitor.sv
// Checker of the LIN wire shared by the master end and the slave end
`timescale 1ns/100ps
module lsh_monitor #(
	parameter int BIT_CYC = 20
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic m_oe,
	input wire logic s_oe,
	input wire logic level
);
	localparam int BRK = 13 * BIT_CYC;
	localparam int MAXB = 9 * BIT_CYC;
	localparam int DL = BIT_CYC - 1;
	logic [15:0] m_run_r;
	logic [15:0] m_gap_r;
	logic [15:0] s_run_r;
	logic [15:0] s_gap_r;

	function automatic logic [15:0] inc(input logic [15:0] v);
		return (v == 16'hFFFF) ? v : v + 16'h0001;
	endfunction : inc

	// Run lengths per driver; saturate so a long idle never wraps
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			m_run_r <= 16'h0000;
			m_gap_r <= 16'hFFFF;
			s_run_r <= 16'h0000;
			s_gap_r <= 16'hFFFF;
		end else begin
			m_run_r <= m_oe ? inc(m_run_r) : 16'h0000;
			m_gap_r <= m_oe ? 16'h0000 : inc(m_gap_r);
			s_run_r <= s_oe ? inc(s_run_r) : 16'h0000;
			s_gap_r <= s_oe ? 16'h0000 : inc(s_gap_r);
		end
	end

	//****************************************************************
	// Wire assertions
	//****************************************************************
	AST_BRK_LEN: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(m_oe) && m_run_r > MAXB |-> m_run_r == BRK)
		else $error("break run has wrong length");
	AST_MBIT_GRID: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(m_oe) |-> m_run_r % BIT_CYC == 0)
		else $error("master low run off the bit grid");
	AST_SYNC_SHAPE: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(m_oe) && m_run_r == BRK |->
		##DL !m_oe ##1 m_oe ##BIT_CYC !m_oe ##BIT_CYC m_oe)
		else $error("delimiter or sync byte shape wrong");
	AST_MGAP_MIN: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(m_oe) |-> m_gap_r >= BIT_CYC)
		else $error("master high run shorter than a bit");
	AST_SBIT_GRID: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(s_oe) && s_run_r <= MAXB |-> s_run_r % BIT_CYC == 0)
		else $error("slave low run off the bit grid");
	AST_SGAP_MIN: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(s_oe) |-> s_gap_r >= BIT_CYC)
		else $error("slave high run shorter than a bit");
	AST_SLV_QUIET: assert property (@(posedge pclk) disable iff (!presetn)
		m_run_r > MAXB |-> !s_oe)
		else $error("slave drives during a break");
	AST_WIRE_REL: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(level) |-> !m_oe && !s_oe && $past(m_oe || s_oe))
		else $error("wire level does not follow the drivers");
endmodule : lsh_monitor

// >>> test/test_lin_slave_header_sync.sv
// Bench: master end and slave end on one LIN wire, slave reached over APB
`timescale 1ns/100ps
`include "lsh_cfg.svh"
module test_lin_slave_header_sync;
	typedef struct {
		string       nm;
		logic [33:0] ev;
		logic [33:0] mk;
	} lsh_note_t;
	localparam int BC = 20;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        irq;
	logic        gpio_txd;
	logic        start;
	logic [5:0]  pid;
	logic [3:0]  ndata;
	logic [63:0] data;
	logic        busy;
	logic        done;
	logic [7:0]  b;
	int          fail_count;
	int          samples_checked;
	int          done_cnt;
	lsh_note_t   notes[$];
	lsh_note_t   nt;
	logic [7:0]  ra[7] = '{`LSH_A_SEL, `LSH_A_DIVL, `LSH_A_DIVH, `LSH_A_FLAGS,
		`LSH_A_LS, `LSH_A_P2DAT, 8'h4C};
	logic [33:0] rv[7] = '{34'h5, 34'h88, 34'h13, 34'h100, 34'h20, 34'h10, 34'h1_0000_0000};
	logic [33:0] rm[7] = '{34'h3_FFFF_FFFF, 34'h3_FFFF_FFFF, 34'h3_FFFF_FFFF,
		34'h3_FFFF_FFFF, 34'h3_FFFF_FFFF, 34'h1_0000_0010, 34'h3_FFFF_FFFF};

	lsh_if i_lsh_if ();
	lsh_slave #(.LPO_DIV(16'h0002)) i_lsh_slave (.pclk(pclk), .presetn(presetn), .ce(1'b1),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
		.gpio_rxd(gpio_txd), .gpio_txd(gpio_txd), .bus(i_lsh_if.slave));
	lsh_master #(.BIT_CYC(BC)) i_lsh_master (.pclk(pclk), .presetn(presetn), .ce(1'b1),
		.start(start), .pid(pid), .ndata(ndata), .data(data), .busy(busy), .done(done),
		.bus(i_lsh_if.master));
	lsh_monitor #(.BIT_CYC(BC)) i_lsh_monitor (.pclk(pclk), .presetn(presetn),
		.m_oe(i_lsh_if.m_oe), .s_oe(i_lsh_if.s_oe), .level(i_lsh_if.level));

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	// Frame ends are counted so a short done pulse is never missed
	always @(posedge pclk) begin
		if (done === 1'b1) done_cnt++;
	end

	// Each completed transfer settles the oldest note; mask 0 means a poll
	always @(posedge pclk) begin
		if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
			nt = notes.pop_front();
			if (nt.mk != 34'h0) check(nt.nm, {irq, pslverr, prdata} & nt.mk, nt.ev & nt.mk);
		end
	end

	//****************************************************************
	// Tasks
	//****************************************************************
	task automatic check(input string nm, input logic [33:0] seen, input logic [33:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	task automatic complete_run;
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : complete_run

	task automatic hang(input string nm);
		fail_count++;
		$display("BAD wait %s expected end seen none", nm);
		complete_run();
	endtask : hang

	// Request held from setup until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [33:0] ev, input logic [33:0] mk, input string nm, output logic [31:0] v);
		int n;
		notes.push_back('{nm, ev, mk});
		@(posedge pclk);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) hang("apb");
		v = prdata;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] v;
		apb(1'b1, a, d, 34'h0, 34'h1_0000_0000, "write", v);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [33:0] ev, input logic [33:0] mk,
		input string nm);
		logic [31:0] v;
		apb(1'b0, a, 32'h0, ev, mk, nm, v);
	endtask : rd

	task automatic poll(input logic [7:0] a, input int bi, input logic val, input int lim);
		logic [31:0] v;
		int          n;
		n = 0;
		v = {32{~val}};
		while (v[bi] !== val && n < lim) begin
			apb(1'b0, a, 32'h0, 34'h0, 34'h0, "poll", v);
			n++;
		end
		if (v[bi] !== val) hang("poll");
	endtask : poll

	// One master frame; ok says whether the break passes the compare
	task automatic frame(input logic [11:0] cmp, input logic ok, input logic [3:0] nb);
		logic [5:0]  id;
		logic [63:0] dt;
		logic [71:0] fr;
		logic [31:0] v;
		int          n0;
		int          n;
		id = 6'($urandom) | 6'h01; // Keeps the id's low run under the default compare
		dt = {$urandom, $urandom} | 64'h1010_1010_1010_1010;
		fr = {dt, ~(id[1] ^ id[3] ^ id[4] ^ id[5]), id[0] ^ id[1] ^ id[2] ^ id[4], id};
		wr(`LSH_A_CTRL, 32'h0000_0104);
		if (cmp != 12'h000) wr(`LSH_A_BTV, {20'h0, cmp});
		wr(`LSH_A_CLR, 32'h0000_001F);
		n0 = done_cnt;
		@(posedge pclk);
		start <= 1'b1;
		pid   <= id;
		ndata <= nb;
		data  <= dt;
		@(posedge pclk);
		start <= 1'b0;
		@(posedge pclk);
		check("busy", {33'h0, busy}, 34'h1);
		if (ok) begin
			poll(`LSH_A_FLAGS, `LSH_I_STOP, 1'b1, 900);
			// Divisor comes from the measured sync cycle count over eight
			apb(1'b0, `LSH_A_ETMR, 32'h0, 34'h0_0014_0000, 34'h0_1FFF_0000, "sync", v);
			wr(`LSH_A_DIVL, {24'h0, v[23:16]});
			wr(`LSH_A_DIVH, {27'h0, v[28:24]});
			poll(`LSH_A_P2DAT, `LSH_P2_RB, 1'b1, 20);
			wr(`LSH_A_CTRL, 32'h0000_0004);
			for (int i = 0; i <= nb; i++) begin
				poll(`LSH_A_LS, `LSH_LS_DR, 1'b1, 200);
				rd(`LSH_A_RX, {26'h0, fr[8*i +: 8]}, 34'hFF, "frame byte");
			end
		end
		n = 0;
		while (done_cnt == n0 && n < 6000) begin
			@(posedge pclk);
			n++;
		end
		if (done_cnt == n0) hang("done");
		if (ok) begin
			rd(`LSH_A_FLAGS, 34'h2_0000_000B, 34'h2_0000_001F, "flags");
			rd(`LSH_A_ETMR, 34'h0_0014_0000, 34'h0_1FFF_0000, "sync");
		end else begin
			rd(`LSH_A_FLAGS, 34'h0, 34'h2_0000_001F, "no sync");
		end
		$display("test frame done");
	endtask : frame

	//****************************************************************
	// Sequence
	//****************************************************************
	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{start, pid, ndata, data} = '0;
		fail_count = 0;
		samples_checked = 0;
		done_cnt = 0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		void'($urandom(32'hAEF3));
		for (int i = 0; i < 7; i++) rd(ra[i], rv[i], rm[i], "reset value");
		$display("test reset done");
		wr(`LSH_A_DIVL, 32'h14);
		wr(`LSH_A_DIVH, 32'h0);
		wr(`LSH_A_IEN, 32'h2);
		wr(`LSH_A_CTRL, 32'h1);
		frame(12'h000, 1'b1, 4'h1);
		frame(12'h0FF, 1'b0, 4'h3);
		frame(12'h078, 1'b1, 4'h8);
		// Bytes sent by the slave come back over the wire, then over the pins
		for (int r = 0; r < 2; r++) begin
			wr(`LSH_A_P1CON, 32'(r));
			for (int k = 0; k < 2; k++) begin
				b = 8'($urandom) | 8'h10;
				wr(`LSH_A_TX, {24'h0, b});
				poll(`LSH_A_LS, `LSH_LS_DR, 1'b1, 200);
				rd(`LSH_A_RX, {26'h0, b}, 34'hFF, "tx loop");
				rd(`LSH_A_LS, 34'h20, 34'h2B, "line state");
			end
		end
		wr(`LSH_A_P1CON, 32'h0);
		$display("test uart done");
		// Pin held low by software until the break timer overflows
		wr(`LSH_A_CLR, 32'h1F);
		wr(`LSH_A_P2DAT, 32'h0);
		wr(`LSH_A_P2CON, 32'h0010_0000);
		poll(`LSH_A_P2DAT, `LSH_P2_RB, 1'b0, 20);
		rd(`LSH_A_P2DAT, 34'h0, 34'h10, "pin low");
		poll(`LSH_A_FLAGS, `LSH_I_BERR, 1'b1, 3000);
		rd(`LSH_A_FLAGS, 34'h4, 34'h2_0000_0004, "masked");
		wr(`LSH_A_P2DAT, 32'h20);
		wr(`LSH_A_P2CON, 32'h0);
		poll(`LSH_A_P2DAT, `LSH_P2_RB, 1'b1, 20);
		wr(`LSH_A_IEN, 32'h4);
		rd(`LSH_A_FLAGS, 34'h2_0000_0004, 34'h2_0000_0004, "raised");
		wr(`LSH_A_CLR, 32'h4);
		rd(`LSH_A_FLAGS, 34'h0, 34'h2_0000_0004, "cleared");
		rd(`LSH_A_BTV, 34'hFFF, 34'h1_0000_0FFF, "timer held");
		rd(`LSH_A_BTV, 34'h0, 34'h1_0000_0FFC, "timer read clear");
		rd(`LSH_A_HV_STATE, 34'h0, 34'h1_0000_0004, "no short");
		$display("test pin done");
		complete_run();
	end
endmodule : test_lin_slave_header_sync
